// file: tpt_pkg.sv
// Constants for the active-matrix panel timing block: register map,
// field positions, reset values and pixel-period timing counts.
// Assumes a host bus with a 17-bit byte address and 8-bit data.
package tpt_pkg;
	// Register window bounds
	localparam logic [16:0] TPT_WIN_LO = 17'h1FFE0;
	localparam logic [16:0] TPT_WIN_HI = 17'h1FFFF;
	// Register offsets (byte addresses)
	localparam logic [16:0] TPT_OFS_ID = 17'h1FFE0;
	localparam logic [16:0] TPT_OFS_MODE = 17'h1FFE1;
	localparam logic [16:0] TPT_OFS_HDISP = 17'h1FFE4;
	localparam logic [16:0] TPT_OFS_VDISP_LO = 17'h1FFE5;
	localparam logic [16:0] TPT_OFS_VDISP_HI = 17'h1FFE6;
	localparam logic [16:0] TPT_OFS_LSTART = 17'h1FFE7;
	localparam logic [16:0] TPT_OFS_HBLANK = 17'h1FFE8;
	localparam logic [16:0] TPT_OFS_VBLANK1 = 17'h1FFE9;
	localparam logic [16:0] TPT_OFS_VBLANK = 17'h1FFEA;
	// Identification codes, values arbitrary
	localparam logic [5:0] TPT_PRODUCT_CODE = 6'h15;
	localparam logic [1:0] TPT_REVISION_CODE = 2'h2;
	// Mode register bit positions
	localparam int TPT_BIT_PANEL_TYPE = 7;
	localparam int TPT_BIT_DUAL = 6;
	localparam int TPT_BIT_COLOUR = 5;
	localparam int TPT_BIT_LINE_POL = 4;
	localparam int TPT_BIT_FRAME_POL = 3;
	localparam int TPT_BIT_MASK_SHIFT = 2;
	// Reset value of every writable register
	localparam logic [7:0] TPT_REG_RESET = 8'h00;
	// Timing counts in pixel periods
	localparam logic [10:0] TPT_LINE_LOW_PIX = 11'h009;
	localparam logic [10:0] TPT_FRAME_LEAD_PIX = 11'h012;
	localparam logic [10:0] TPT_HB_PART_PIX = 11'h010;
	localparam logic [10:0] TPT_HB_EXTRA_PIX = 11'h020;
	localparam logic [10:0] TPT_PIX_PER_UNIT = 11'h008;
	// Pixel stream shape
	localparam int TPT_PIX_W = 12;
	localparam int TPT_FIFO_D = 8;
endpackage

// file: tpt_panel_timing.sv
// Active-matrix panel timing generator with its host register window and
// a small pixel FIFO. Assumes host bus strobes are synchronous to i_clk
// and the pixel clock pin is asynchronous and far slower than i_clk.
//
// Operation
// - Active lines are vertical display field plus one
// - Vertical blank lines split into two parts
// - First vertical blank part from separate field
// - Active pixels are eight times field plus eight
// - Horizontal blank is eight times field plus 32
// - First horizontal blank part: eight times start field, plus 16
// - Shift clock mirrors pixel clock in active mode
// - Line pulse active nine pixel periods each line
// - Frame pulse active for two full lines
// - Frame pulse leads line pulse by line minus 18
// - Data strobe active for the horizontal active period
// - Strobe end to line pulse: start field gap
// - Strobe and data change together, stable at fall
// - Strobe starts after second horizontal blank part
// - Decode only with select low inside window
// - Registers clear at reset; reserved bits write zero
// - Mode bit 7 selects active-matrix panel
// - Mode bit 4 sets line pulse polarity on active-matrix panels only
// - Mode bit 3 sets frame pulse polarity on active-matrix panels only
// - Shift clock held low during blank when masked
// - Masking when colour passive or mode bit 2
`timescale 1ns/10ps
`default_nettype none

// Pixel FIFO, flip-flop storage, registered input-side ready
module tpt_pixel_fifo #(
	parameter int W = 12,
	parameter int D = 8
) (
	// Clock, reset, enable
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_ce,
	// Filling side
	input wire logic i_in_valid,
	output logic o_in_ready,
	input wire logic [W-1:0] i_in_data,
	// Draining side
	output logic o_out_valid,
	input wire logic i_out_ready,
	output logic [W-1:0] o_out_data
);
	localparam int AW = $clog2(D);
	localparam logic [AW:0] FULL_CNT = (AW+1)'(D);
	localparam logic [AW-1:0] LAST_IDX = (AW)'(D - 1);

	logic [W-1:0] mem_r [D]; // Storage words
	logic [W-1:0] mem_nxt [D];
	logic [AW-1:0] wr_r, wr_nxt; // Write index
	logic [AW-1:0] rd_r, rd_nxt; // Read index
	logic [AW:0] cnt_r, cnt_nxt; // Occupancy
	logic rdy_r, rdy_nxt; // Registered not-full
	logic push, pop;

	assign o_in_ready = rdy_r;
	assign o_out_valid = (cnt_r != '0);
	assign o_out_data = mem_r[rd_r];

	// Next pointers, count and storage
	always_comb begin
		push = i_in_valid && rdy_r;
		pop = i_out_ready && (cnt_r != '0);
		mem_nxt = mem_r;
		wr_nxt = wr_r;
		rd_nxt = rd_r;
		cnt_nxt = cnt_r;
		if (push) begin
			mem_nxt[wr_r] = i_in_data;
			wr_nxt = (wr_r == LAST_IDX) ? '0 : wr_r + 1'b1;
		end
		if (pop) begin
			rd_nxt = (rd_r == LAST_IDX) ? '0 : rd_r + 1'b1;
		end
		// Push and pop together leave the count alone
		if (push && !pop) begin
			cnt_nxt = cnt_r + 1'b1;
		end else if (pop && !push) begin
			cnt_nxt = cnt_r - 1'b1;
		end
		rdy_nxt = (cnt_nxt != FULL_CNT);
	end

	// Register stage; storage needs no reset
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			wr_r <= '0;
			rd_r <= '0;
			cnt_r <= '0;
			rdy_r <= 1'b0;
		end else if (i_ce) begin
			wr_r <= wr_nxt;
			rd_r <= rd_nxt;
			cnt_r <= cnt_nxt;
			rdy_r <= rdy_nxt;
		end
		if (i_ce) begin
			mem_r <= mem_nxt;
		end
	end
endmodule // tpt_pixel_fifo

module tpt_panel_timing import tpt_pkg::*; (
	// Clock, reset, enable
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_ce,
	// Host register bus
	input wire logic i_cs_n,
	input wire logic [16:0] i_host_address_bus,
	input wire logic i_rd_n,
	input wire logic i_we_n,
	input wire logic [7:0] i_host_wdata,
	output logic [7:0] o_host_rdata,
	// Pixel clock pin
	input wire logic i_pixel_clk,
	// Pixel stream in
	input wire logic i_pix_valid,
	input wire logic [TPT_PIX_W-1:0] i_pix_data,
	output logic o_pix_ready,
	// Panel pins
	output logic o_shift_clock_out,
	output logic o_line_pulse,
	output logic o_frame_pulse,
	output logic o_data_valid_strobe,
	output logic [TPT_PIX_W-1:0] o_panel_pixel_data
);
	// Window decode, used by read and write paths
	function automatic logic in_window(input logic cs_n, input logic [16:0] a);
		in_window = !cs_n && (a >= TPT_WIN_LO) && (a <= TPT_WIN_HI);
	endfunction

	// Register state
	logic [7:0] mode_r, mode_nxt; // Panel mode select
	logic [6:0] hdisp_r, hdisp_nxt; // Horizontal display field
	logic [7:0] vdlo_r, vdlo_nxt; // Vertical display low bits
	logic [1:0] vdhi_r, vdhi_nxt; // Vertical display high bits
	logic [4:0] lstart_r, lstart_nxt; // Line-pulse start field
	logic [4:0] hblank_r, hblank_nxt; // Horizontal non-display field
	logic [5:0] vb1_r, vb1_nxt; // First vertical blank part
	logic [5:0] vb_r, vb_nxt; // Total vertical blank
	logic [7:0] rdata_r, rdata_nxt; // Read data
	logic hit;

	// Register write and read decode
	always_comb begin
		mode_nxt = mode_r;
		hdisp_nxt = hdisp_r;
		vdlo_nxt = vdlo_r;
		vdhi_nxt = vdhi_r;
		lstart_nxt = lstart_r;
		hblank_nxt = hblank_r;
		vb1_nxt = vb1_r;
		vb_nxt = vb_r;
		rdata_nxt = 8'h00;
		hit = in_window(i_cs_n, i_host_address_bus);
		// Writes; the identification register has no write path
		if (hit && !i_we_n) begin
			if (i_host_address_bus == TPT_OFS_MODE) begin
				mode_nxt = i_host_wdata;
			end else if (i_host_address_bus == TPT_OFS_HDISP) begin
				hdisp_nxt = i_host_wdata[6:0];
			end else if (i_host_address_bus == TPT_OFS_VDISP_LO) begin
				vdlo_nxt = i_host_wdata;
			end else if (i_host_address_bus == TPT_OFS_VDISP_HI) begin
				vdhi_nxt = i_host_wdata[1:0];
			end else if (i_host_address_bus == TPT_OFS_LSTART) begin
				lstart_nxt = i_host_wdata[4:0];
			end else if (i_host_address_bus == TPT_OFS_HBLANK) begin
				hblank_nxt = i_host_wdata[4:0];
			end else if (i_host_address_bus == TPT_OFS_VBLANK1) begin
				vb1_nxt = i_host_wdata[5:0];
			end else if (i_host_address_bus == TPT_OFS_VBLANK) begin
				vb_nxt = i_host_wdata[5:0];
			end
		end
		// Reads; unused window bytes and unselected reads return zero
		if (hit && !i_rd_n) begin
			if (i_host_address_bus == TPT_OFS_ID) begin
				rdata_nxt = {TPT_PRODUCT_CODE, TPT_REVISION_CODE};
			end else if (i_host_address_bus == TPT_OFS_MODE) begin
				rdata_nxt = mode_r;
			end else if (i_host_address_bus == TPT_OFS_HDISP) begin
				rdata_nxt = {1'b0, hdisp_r};
			end else if (i_host_address_bus == TPT_OFS_VDISP_LO) begin
				rdata_nxt = vdlo_r;
			end else if (i_host_address_bus == TPT_OFS_VDISP_HI) begin
				rdata_nxt = {6'h00, vdhi_r};
			end else if (i_host_address_bus == TPT_OFS_LSTART) begin
				rdata_nxt = {3'h0, lstart_r};
			end else if (i_host_address_bus == TPT_OFS_HBLANK) begin
				rdata_nxt = {3'h0, hblank_r};
			end else if (i_host_address_bus == TPT_OFS_VBLANK1) begin
				rdata_nxt = {2'h0, vb1_r};
			end else if (i_host_address_bus == TPT_OFS_VBLANK) begin
				rdata_nxt = {2'h0, vb_r};
			end
		end
	end

	// Register file; everything clears at reset
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			mode_r <= TPT_REG_RESET;
			hdisp_r <= '0;
			vdlo_r <= TPT_REG_RESET;
			vdhi_r <= '0;
			lstart_r <= '0;
			hblank_r <= '0;
			vb1_r <= '0;
			vb_r <= '0;
			rdata_r <= 8'h00;
		end else if (i_ce) begin
			mode_r <= mode_nxt;
			hdisp_r <= hdisp_nxt;
			vdlo_r <= vdlo_nxt;
			vdhi_r <= vdhi_nxt;
			lstart_r <= lstart_nxt;
			hblank_r <= hblank_nxt;
			vb1_r <= vb1_nxt;
			vb_r <= vb_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	// Mode decode; colour bit only matters for passive panels, dual bit is not used
	logic tft, line_pol, frame_pol, mask_on;
	assign tft = mode_r[TPT_BIT_PANEL_TYPE];
	assign line_pol = tft && mode_r[TPT_BIT_LINE_POL];
	assign frame_pol = tft && mode_r[TPT_BIT_FRAME_POL];
	assign mask_on = (!tft && mode_r[TPT_BIT_COLOUR]) || mode_r[TPT_BIT_MASK_SHIFT];

	// Derived line and frame geometry in pixel periods and lines
	logic [10:0] horizontal_active_period, hs, he, ltot, vertical_active_lines, vtot, vnd2;
	always_comb begin
		horizontal_active_period = {1'b0, hdisp_r, 3'b000} + TPT_PIX_PER_UNIT;
		// Second blank part; start field above blank field wraps
		hs = {3'b000, 5'(hblank_r - lstart_r), 3'b000} + TPT_HB_PART_PIX;
		he = hs + horizontal_active_period;
		// First part fills the rest: start field times eight plus 16
		ltot = horizontal_active_period + {3'b000, hblank_r, 3'b000} + TPT_HB_EXTRA_PIX;
		vertical_active_lines = {1'b0, vdhi_r, vdlo_r} + 11'h001;
		vtot = vertical_active_lines + {5'h00, vb_r};
		vnd2 = {5'h00, 6'(vb_r - vb1_r)};
	end

	// Pixel clock pin synchroniser and rising-edge finder
	logic pc_m_r, pc_s_r, pc_d_r, pix_tick;
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			pc_m_r <= 1'b0;
			pc_s_r <= 1'b0;
			pc_d_r <= 1'b0;
		end else if (i_ce) begin
			pc_m_r <= i_pixel_clk;
			pc_s_r <= pc_m_r;
			pc_d_r <= pc_s_r;
		end
	end
	assign pix_tick = pc_s_r && !pc_d_r;

	// Timing state
	logic [10:0] h_r, h_nxt; // Pixel within line, 0 at line pulse start
	logic [10:0] v_r, v_nxt; // Line within frame, 0 at frame reference
	logic line_act_r, line_act_nxt;
	logic frame_act_r, frame_act_nxt;
	logic dv_r, dv_nxt;
	logic [TPT_PIX_W-1:0] dat_r, dat_nxt;
	logic shift_r, shift_nxt, lp_out_r, lp_out_nxt, fp_out_r, fp_out_nxt;
	logic fifo_valid, fifo_pop;
	logic [TPT_PIX_W-1:0] fifo_data;

	// Counters and line, frame and strobe levels advance on the pixel clock rise; shift follows the pin
	always_comb begin
		h_nxt = h_r;
		v_nxt = v_r;
		line_act_nxt = line_act_r;
		frame_act_nxt = frame_act_r;
		dv_nxt = dv_r;
		dat_nxt = dat_r;
		fifo_pop = 1'b0;
		if (pix_tick) begin
			// Wrap with >= so a shortened line never runs away
			if (h_r >= ltot - 11'h001) begin
				h_nxt = '0;
				v_nxt = (v_r >= vtot - 11'h001) ? '0 : v_r + 11'h001;
			end else begin
				h_nxt = h_r + 11'h001;
			end
			line_act_nxt = (h_nxt < TPT_LINE_LOW_PIX);
			// Two lines long, starting 18 pixels into the line before
			frame_act_nxt = (v_nxt == vtot - 11'h001 && h_nxt >= TPT_FRAME_LEAD_PIX)
				|| (v_nxt == 11'h000)
				|| (v_nxt == 11'h001 && h_nxt < TPT_FRAME_LEAD_PIX);
			// Opens only at its true start, so no short pulse follows reset
			frame_act_nxt = frame_act_nxt && (frame_act_r || v_nxt == vtot - 11'h001);
			dv_nxt = (v_nxt >= vnd2) && (v_nxt < vnd2 + vertical_active_lines)
				&& (h_nxt >= hs) && (h_nxt < he);
			// Data moves with the strobe on the same edge
			fifo_pop = dv_nxt && fifo_valid;
			dat_nxt = fifo_pop ? fifo_data : '0;
		end
		// Masked shift clock stays low through blanking
		shift_nxt = pc_s_r && !(mask_on && !dv_nxt);
		lp_out_nxt = line_pol ? line_act_nxt : !line_act_nxt;
		fp_out_nxt = frame_pol ? frame_act_nxt : !frame_act_nxt;
	end

	// Timing registers; outputs idle at their inactive levels
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			// Parked at the wrap point so the first tick opens line 0
			h_r <= '1;
			v_r <= '1;
			line_act_r <= 1'b0;
			frame_act_r <= 1'b0;
			dv_r <= 1'b0;
			dat_r <= '0;
			shift_r <= 1'b0;
			lp_out_r <= 1'b1;
			fp_out_r <= 1'b1;
		end else if (i_ce) begin
			h_r <= h_nxt;
			v_r <= v_nxt;
			line_act_r <= line_act_nxt;
			frame_act_r <= frame_act_nxt;
			dv_r <= dv_nxt;
			dat_r <= dat_nxt;
			shift_r <= shift_nxt;
			lp_out_r <= lp_out_nxt;
			fp_out_r <= fp_out_nxt;
		end
	end

	// Pixel FIFO; an empty FIFO during display sends zero pixels
	tpt_pixel_fifo #(
		.W(TPT_PIX_W),
		.D(TPT_FIFO_D)
	) u_fifo (
		.i_clk(i_clk),
		.i_rst_n(i_rst_n),
		.i_ce(i_ce),
		.i_in_valid(i_pix_valid),
		.o_in_ready(o_pix_ready),
		.i_in_data(i_pix_data),
		.o_out_valid(fifo_valid),
		.i_out_ready(fifo_pop),
		.o_out_data(fifo_data)
	);

	assign o_host_rdata = rdata_r;
	assign o_shift_clock_out = shift_r;
	assign o_line_pulse = lp_out_r;
	assign o_frame_pulse = fp_out_r;
	assign o_data_valid_strobe = dv_r;
	assign o_panel_pixel_data = dat_r;

	// Helper counters of pixel periods spent in each pulse
	logic [11:0] dv_cnt_r, lp_cnt_r, fp_cnt_r;
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			dv_cnt_r <= '0;
			lp_cnt_r <= '0;
			fp_cnt_r <= '0;
		end else if (i_ce && pix_tick) begin
			dv_cnt_r <= dv_r ? dv_cnt_r + 12'h001 : 12'h000;
			lp_cnt_r <= line_act_r ? lp_cnt_r + 12'h001 : 12'h000;
			fp_cnt_r <= frame_act_r ? fp_cnt_r + 12'h001 : 12'h000;
		end
	end

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);

	sequence s_read_id;
		i_ce && in_window(i_cs_n, i_host_address_bus) && !i_rd_n
			&& i_host_address_bus == TPT_OFS_ID;
	endsequence

	chk_strobe_width: assert property (i_ce && pix_tick && dv_r && !dv_nxt
		|-> dv_cnt_r + 12'h001 == {1'b0, horizontal_active_period})
		else $error("data strobe width differs from active period");
	chk_line_low: assert property (i_ce && pix_tick && line_act_r && !line_act_nxt
		|-> lp_cnt_r + 12'h001 == {1'b0, TPT_LINE_LOW_PIX})
		else $error("line pulse active width wrong");
	chk_frame_two_lines: assert property (i_ce && pix_tick && frame_act_r && !frame_act_nxt
		|-> fp_cnt_r + 12'h001 == {ltot, 1'b0})
		else $error("frame pulse not two lines long");
	chk_frame_lead: assert property ($rose(frame_act_r) |-> h_r == TPT_FRAME_LEAD_PIX)
		else $error("frame pulse lead over line pulse wrong");
	chk_strobe_start: assert property ($rose(dv_r) |-> h_r == hs)
		else $error("data strobe start after line pulse wrong");
	chk_data_on_tick: assert property ($changed(o_panel_pixel_data) |-> $past(pix_tick))
		else $error("pixel data changed away from shift rise");
	chk_mask_blank: assert property (o_shift_clock_out |-> $past(!mask_on) || o_data_valid_strobe)
		else $error("shift clock toggles in masked blank");
	chk_id_read: assert property (s_read_id |=> o_host_rdata == {TPT_PRODUCT_CODE,
		TPT_REVISION_CODE})
		else $error("identification read wrong");
	chk_decode_window: assert property (i_ce && (i_cs_n || i_host_address_bus < TPT_WIN_LO)
		|=> o_host_rdata == 8'h00)
		else $error("read answered outside register window");
	chk_line_polarity: assert property ($past(i_ce) |-> o_line_pulse
		== ($past(line_pol) ? line_act_r : !line_act_r))
		else $error("line pulse polarity wrong");
	chk_reset_clear: assert property ($past(!i_rst_n) |-> mode_r == TPT_REG_RESET)
		else $error("mode register not cleared by reset");
endmodule // tpt_panel_timing

`default_nettype wire

// file: tpt_panel_model.sv
// Panel-side model: makes the pixel clock and measures the panel pins.
// Assumes panel pins are registered on i_clk; figures are in i_clk cycles, except o_m[7], a count of shift rises.
`timescale 1ns/10ps
`default_nettype none
module tpt_panel_model import tpt_pkg::*; (
	// System clock and bench controls
	input wire logic i_clk,
	input wire logic i_run,
	input wire logic i_line_hi,
	input wire logic i_frame_hi,
	// Panel pins seen by the panel
	input wire logic i_shift,
	input wire logic i_line,
	input wire logic i_frame,
	input wire logic i_strobe,
	input wire logic [TPT_PIX_W-1:0] i_data,
	// Pixel clock and measured figures
	output logic o_pixel_clk,
	output logic [9:0][15:0] o_m,
	output logic [15:0] o_data_err
);
	logic la; // Line pulse active
	logic fa; // Frame pulse active
	logic lr; // Line pulse start
	logic fr; // Frame pulse start
	logic sf; // Strobe end
	logic br; // Shift rise outside strobe
	logic la_d = 1'b0, fa_d = 1'b0, st_d = 1'b0, sh_d = 1'b0;
	logic arm_g = 1'b0, arm_l = 1'b0; // Gap figures only after a strobe or frame start
	logic arm_v = 1'b0; // First strobe after a frame start still to come
	logic [15:0] c_sh = '0; // Cycles the shift clock stands high
	logic [15:0] c_ln = '0, c_st = '0, c_fr = '0, c_per = '0;
	logic [15:0] c_gap = '0, c_go = '0, c_ld = '0, c_bl = '0;
	logic [TPT_PIX_W-1:0] exp_d = '0; // Next word the stream should show
	// Clock stands low until the bench lets the panel run
	initial begin
		o_pixel_clk = 1'b0;
		o_m = '0;
		o_data_err = '0;
		forever #80 o_pixel_clk = i_run & ~o_pixel_clk;
	end
	assign la = (i_line === i_line_hi);
	assign fa = (i_frame === i_frame_hi);
	assign lr = la & !la_d;
	assign fr = fa & !fa_d;
	assign sf = st_d & !i_strobe;
	assign br = i_shift & !sh_d & !i_strobe;
	// Width, period and gap counters
	always @(posedge i_clk) begin
		la_d <= la;
		fa_d <= fa;
		st_d <= i_strobe;
		sh_d <= i_shift;
		c_ln <= la ? c_ln + 16'h0001 : 16'h0000;
		c_st <= i_strobe ? c_st + 16'h0001 : 16'h0000;
		c_fr <= fa ? c_fr + 16'h0001 : 16'h0000;
		c_per <= lr ? 16'h0001 : c_per + 16'h0001;
		c_gap <= sf ? 16'h0001 : c_gap + 16'h0001;
		c_go <= lr ? 16'h0001 : c_go + 16'h0001;
		c_ld <= fr ? 16'h0001 : c_ld + 16'h0001;
		c_bl <= fr ? {15'h0000, br} : c_bl + {15'h0000, br};
		c_sh <= i_shift ? c_sh + 16'h0001 : 16'h0000;
		if (la_d && !la) o_m[0] <= c_ln;
		if (lr) o_m[1] <= c_per;
		if (sf) o_m[2] <= c_st;
		if (lr && arm_g) o_m[3] <= c_gap;
		if (i_strobe && !st_d) o_m[4] <= c_go;
		if (fa_d && !fa) o_m[5] <= c_fr;
		if (lr && arm_l) o_m[6] <= c_ld;
		if (fr) o_m[7] <= c_bl;
		if (i_strobe && !st_d && arm_v) o_m[8] <= c_ld;
		if (sh_d && !i_shift) o_m[9] <= c_sh;
		arm_g <= sf | (arm_g & !lr);
		arm_l <= fr | (arm_l & !lr);
		arm_v <= fr | (arm_v & !(i_strobe & !st_d));
		// Panel samples the word at the shift falling edge
		if (sh_d && !i_shift && i_strobe) begin
			o_data_err <= o_data_err + {15'h0000, i_data !== exp_d};
			exp_d <= exp_d + 12'h001;
		end
	end
endmodule // tpt_panel_model
`default_nettype wire

// file: testbench.sv
// Self-checking bench for the panel timing block with a panel model.
// Assumes i_ce tied high and a host bus synchronous to i_clk.
`timescale 1ns/10ps
`default_nettype none
module testbench import tpt_pkg::*;;
	localparam int HD = 1; // Horizontal display field
	localparam int HB = 2; // Horizontal blank field
	localparam int LS = 1; // Line-pulse start field
	localparam int VD = 2; // Vertical display field
	localparam int VB = 3; // Vertical blank field
	localparam int V1 = 1; // First vertical blank part field
	localparam int HORIZONTAL_ACTIVE_PERIOD = (HD + 1) * 8;
	localparam int LN = HORIZONTAL_ACTIVE_PERIOD + (HB + 4) * 8;
	localparam int NBL = (VD + 1 + VB) * LN - (VD + 1) * HORIZONTAL_ACTIVE_PERIOD;
	localparam int K = 8; // Clock cycles per pixel period
	localparam int LIMIT = 60000;
	typedef struct packed {logic [16:0] a; logic [7:0] d; logic [7:0] e;} tpt_row_t;
	typedef struct packed {logic [7:0] v; logic lh; logic fh; logic msk;} tpt_mode_t;
	// Write then read back; last row is an unmapped byte
	tpt_row_t rows [10] = '{'{TPT_OFS_ID, 8'hFF, {TPT_PRODUCT_CODE, TPT_REVISION_CODE}},
		'{TPT_OFS_MODE, 8'h80, 8'h80}, '{TPT_OFS_HDISP, 8'(HD), 8'(HD)},
		'{TPT_OFS_VDISP_LO, 8'(VD), 8'(VD)}, '{TPT_OFS_VDISP_HI, 8'h00, 8'h00},
		'{TPT_OFS_LSTART, 8'(LS), 8'(LS)}, '{TPT_OFS_HBLANK, 8'(HB), 8'(HB)},
		'{TPT_OFS_VBLANK1, 8'(V1), 8'(V1)}, '{TPT_OFS_VBLANK, 8'(VB), 8'(VB)},
		'{17'h1FFF0, 8'h5A, 8'h00}};
	// Mode byte, expected active levels, shift masked in blank
	tpt_mode_t modes [6] = '{'{8'h80, 1'b0, 1'b0, 1'b0}, '{8'h98, 1'b1, 1'b1, 1'b0},
		'{8'h84, 1'b0, 1'b0, 1'b1}, '{8'h18, 1'b0, 1'b0, 1'b0},
		'{8'h20, 1'b0, 1'b0, 1'b1}, '{8'hE0, 1'b0, 1'b0, 1'b0}};
	logic clk = 1'b0, rst_n = 1'b0, cs_n = 1'b1, rd_n = 1'b1, we_n = 1'b1;
	logic [16:0] addr = '0;
	logic [7:0] wdata = '0, rdata, d;
	logic pix_valid = 1'b0, run = 1'b0, line_hi = 1'b0, frame_hi = 1'b0;
	logic [TPT_PIX_W-1:0] pix_data = '0, pdata;
	logic pix_ready, shift, line, frame, strobe, pclk;
	logic [9:0][15:0] m;
	logic [15:0] derr, accepted = '0;
	int mismatches = 0, checked = 0, cycles = 0;
	// Clock at 50 MHz
	always #10 clk = ~clk;
	tpt_panel_timing u_tpt_panel_timing (.i_clk(clk), .i_rst_n(rst_n), .i_ce(1'b1),
		.i_cs_n(cs_n), .i_host_address_bus(addr), .i_rd_n(rd_n), .i_we_n(we_n),
		.i_host_wdata(wdata), .o_host_rdata(rdata), .i_pixel_clk(pclk),
		.i_pix_valid(pix_valid), .i_pix_data(pix_data), .o_pix_ready(pix_ready),
		.o_shift_clock_out(shift), .o_line_pulse(line), .o_frame_pulse(frame),
		.o_data_valid_strobe(strobe), .o_panel_pixel_data(pdata));
	tpt_panel_model u_tpt_panel_model (.i_clk(clk), .i_run(run), .i_line_hi(line_hi),
		.i_frame_hi(frame_hi), .i_shift(shift), .i_line(line), .i_frame(frame),
		.i_strobe(strobe), .i_data(pdata), .o_pixel_clk(pclk), .o_m(m),
		.o_data_err(derr));
	// Pixel source: a counting stream, word held until taken
	always @(posedge clk) begin
		if (pix_valid && pix_ready) begin
			pix_data <= pix_data + 12'h001;
			accepted <= accepted + 16'h0001;
		end
	end
	// Hang guard
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == LIMIT) begin
			mismatches++;
			results();
		end
	end
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			mismatches++;
			$display("ERROR %0t: got %h, expected %h", $time, got, exp);
		end
	endtask
	// One-cycle write; cs lets a deselected access be tried
	task automatic wr(input logic cs, input logic [16:0] a, input logic [7:0] v);
		@(posedge clk);
		cs_n <= cs;
		addr <= a;
		wdata <= v;
		we_n <= 1'b0;
		@(posedge clk);
		cs_n <= 1'b1;
		we_n <= 1'b1;
	endtask
	// One-cycle read; data stands the cycle after the taking edge
	task automatic rd(input logic cs, input logic [16:0] a, output logic [7:0] v);
		@(posedge clk);
		cs_n <= cs;
		addr <= a;
		rd_n <= 1'b0;
		@(posedge clk);
		cs_n <= 1'b1;
		rd_n <= 1'b1;
		#1 v = rdata;
	endtask
	task automatic results;
		if (mismatches == 0 && checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		chk({15'h0000, line}, 16'h0001);
		// Every writable byte clears at reset
		for (int a = 1; a < 11; a++) begin
			rd(1'b0, TPT_OFS_ID + 17'(a), d);
			chk({8'h00, d}, 16'h0000);
		end
		rd(1'b1, TPT_OFS_ID, d);
		chk({8'h00, d}, 16'h0000);
		// Fill the FIFO with the panel clock stopped
		@(posedge clk);
		pix_valid <= 1'b1;
		repeat (20) @(posedge clk);
		chk(accepted, 16'(TPT_FIFO_D));
		chk({15'h0000, pix_ready}, 16'h0000);
		foreach (rows[i]) begin
			wr(1'b0, rows[i].a, rows[i].d);
			rd(1'b0, rows[i].a, d);
			chk({8'h00, d}, {8'h00, rows[i].e});
		end
		wr(1'b1, TPT_OFS_MODE, 8'hFF);
		rd(1'b0, TPT_OFS_MODE, d);
		chk({8'h00, d}, 16'h0080);
		// Geometry is complete before the panel clock starts
		run <= 1'b1;
		// Settle two frames per mode, then compare the panel figures
		foreach (modes[i]) begin
			wr(1'b0, TPT_OFS_MODE, modes[i].v);
			line_hi <= modes[i].lh;
			frame_hi <= modes[i].fh;
			repeat (7000) @(posedge clk);
			chk(m[0], 16'(9 * K));
			chk(m[1], 16'(LN * K));
			chk(m[2], 16'(HORIZONTAL_ACTIVE_PERIOD * K));
			chk(m[3], 16'((LS * 8 + 16) * K));
			chk(m[4], 16'(((HB - LS) * 8 + 16) * K));
			chk(m[5], 16'(2 * LN * K));
			chk(m[6], 16'((LN - 18) * K));
			chk(m[7], modes[i].msk ? 16'h0000 : 16'(NBL));
			chk(m[8], 16'((LN - 18 + (VB - V1) * LN + (HB - LS) * 8 + 16) * K));
			chk(m[9], 16'(K / 2));
			chk(derr, 16'h0000);
		end
		results();
	end
endmodule // testbench
`default_nettype wire
